// *** fault_status_defs.svh ***
// Offsets, field positions, reset values and timing counts of the
// fault and warning status block.
// Assumes a 20 MHz clock and an 8-bit register address.
`ifndef FAULT_STATUS_DEFS_SVH
`define FAULT_STATUS_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_IGBT_TEMP     8'h4A
`define OFS_STATUS_WORD   8'h8F
`define OFS_DC_LINK       8'hEB
`define OFS_CONTROL       8'hF0
`define OFS_IRQ_STATUS    8'hF1
`define OFS_IRQ_MASK      8'hF2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_READY         0
`define BIT_ERROR         1
`define BIT_STARTUP       2
`define BIT_WARN_BASE     16
`define BIT_CLEAR_CMD     0
`define IRQ_ERROR         0
`define IRQ_WARNING       1
`define IRQ_CLEARED       2
`define ERR_OVERVOLTAGE   8
`define WARN_RUN_SIGNAL   1
`define WARN_FE_INACTIVE  2
`define WARN_DETECT       0
`define WARN_SUPPLY_LOW   5
`define WARN_MOTOR_TEMP   6
`define WARN_UNIT_TEMP    7
`define WARN_OVERVOLTAGE  8
`define WARN_OVERCURRENT  9
`define WARN_OVERLOAD     12
`define WARN_BALLAST      15

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_IRQ_MASK      3'h0
`define RST_WORD16        16'h0000

// ----------------------------------------------------------------------
// Scaling and thresholds
// ----------------------------------------------------------------------
`define SCALE_48V_Q8      17'h16238
`define SCALE_96V_Q8      17'h0B11C
`define SCALE_SHIFT       12
`define DC_SATURATE       16'h7FFF
`define DC_WARN_LIMIT     16'h639F
`define DC_ERROR_LIMIT    16'h778C
`define PCT_HOT_LIMIT     9'h057
`define PCT_PEAK_LIMIT    9'h0C8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_KHZ           20000
`define BLINK_MS          500
`define BLINK_CYCLES      (`BLINK_MS * `CLK_KHZ)

`endif

// *** fault_status_pkg.sv ***
// Types of the fault and warning status block.
// Sets the drive-state codes itself; takes no constants from fault_status_defs.svh.
package fault_status_pkg;

    typedef enum logic [1:0] {
        ST_NORMAL  = 2'b00,
        ST_WARNING = 2'b01,
        ST_ERROR   = 2'b10
    } drive_state_t;

    typedef struct packed {
        drive_state_t state;
        logic [15:0]  error_latch;
        logic [15:0]  warn;
        logic [15:0]  dc_reading;
        logic [15:0]  igbt_temp;
        logic         startup_seen;
        logic         startup_fault;
        logic [23:0]  blink_cnt;
        logic         blink_phase;
        logic         fault_lamp;
        logic [3:0]   seg_digit;
        logic         seg_digit_en;
        logic         seg_status_en;
        logic         ready_flag;
        logic         ready_relay_contact;
        logic         ready_indicator;
        logic [2:0]   irq_status;
        logic [2:0]   irq_mask;
        logic         irq;
        logic [31:0]  rdata;
    } status_state_t;

endpackage : fault_status_pkg

// *** fault_warning_status_logic.sv ***
// Fault lamp, error latch, warning flags, ready outputs and DC-link
// scaling of a servo controller, with a plain register port.
// Assumes synchronous inputs, one 20 MHz clock, error sources as pulses.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "fault_status_defs.svh"

module fault_warning_status_logic #(
    parameter int unsigned BLINK_CYCLES = `BLINK_CYCLES,
    parameter bit          VARIANT_96V  = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic [15:0] error_event,
    input  wire logic        clear_errors_input,
    input  wire logic        drive_release_input,
    input  wire logic        detect_inconsistent,
    input  wire logic        run_signal_warning,
    input  wire logic        fe_inactive,
    input  wire logic        supply_low,
    input  wire logic [8:0]  motor_temp_pct,
    input  wire logic [8:0]  unit_temp_pct,
    input  wire logic [8:0]  current_pct,
    input  wire logic [8:0]  thermal_overload_pct,
    input  wire logic [8:0]  ballast_pct,
    input  wire logic [15:0] link_voltage_q4,
    input  wire logic [15:0] igbt_temp_raw,
    output logic             fault_lamp,
    output logic      [3:0]  seg_digit,
    output logic             seg_digit_en,
    output logic             seg_status_en,
    output logic             ready_relay_contact,
    output logic             ready_indicator,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] lowest_set(input logic [15:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : lowest_set

    function automatic logic [15:0] scale_link(input logic [15:0] v,
                                               input logic        hi);
        logic [32:0] prod;
        logic [20:0] cnt;
        prod = {17'h0, v} * {16'h0, (hi ? `SCALE_96V_Q8 : `SCALE_48V_Q8)};
        cnt  = prod[`SCALE_SHIFT +: 21];
        if (cnt > {5'h0, `DC_SATURATE}) begin
            return `DC_SATURATE;
        end
        return cnt[15:0];
    endfunction : scale_link

    localparam logic [23:0] BLINK_LAST = 24'(BLINK_CYCLES - 1);

    fault_status_pkg::status_state_t s_reg;
    fault_status_pkg::status_state_t s_next;

    logic        clear_req;
    logic [15:0] err_in;
    logic [15:0] warn_in;
    logic [2:0]  irq_ev;
    logic        is_error;
    logic        is_warning;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;

        // Measurements
        s_next.dc_reading = scale_link(link_voltage_q4, VARIANT_96V);
        s_next.igbt_temp  = igbt_temp_raw;

        // Warning conditions, live each cycle
        warn_in = 16'h0000;
        warn_in[`WARN_DETECT]      = detect_inconsistent;
        warn_in[`WARN_RUN_SIGNAL]  = run_signal_warning;
        warn_in[`WARN_FE_INACTIVE] = fe_inactive;
        warn_in[`WARN_SUPPLY_LOW]  = supply_low;
        warn_in[`WARN_MOTOR_TEMP]  = motor_temp_pct > `PCT_HOT_LIMIT;
        warn_in[`WARN_UNIT_TEMP]   = unit_temp_pct > `PCT_HOT_LIMIT;
        warn_in[`WARN_OVERVOLTAGE] = s_next.dc_reading > `DC_WARN_LIMIT;
        warn_in[`WARN_OVERCURRENT] = current_pct > `PCT_PEAK_LIMIT;
        warn_in[`WARN_OVERLOAD]    = thermal_overload_pct > `PCT_HOT_LIMIT;
        warn_in[`WARN_BALLAST]     = ballast_pct > `PCT_HOT_LIMIT;
        s_next.warn = warn_in;

        // Error latch: set wins over clear, release plays no part
        err_in = error_event;
        err_in[`ERR_OVERVOLTAGE] = error_event[`ERR_OVERVOLTAGE]
                                   | (s_next.dc_reading > `DC_ERROR_LIMIT);
        clear_req = clear_errors_input
                    | (wr && addr == `OFS_CONTROL && wdata[`BIT_CLEAR_CMD]);
        s_next.error_latch = (s_reg.error_latch & ~{16{clear_req}}) | err_in;

        // Release already active at power-up
        s_next.startup_seen = 1'b1;
        if (!s_reg.startup_seen && drive_release_input) begin
            s_next.startup_fault = 1'b1;
        end else if (clear_req) begin
            s_next.startup_fault = 1'b0;
        end

        // Operating state
        if (s_next.error_latch != 16'h0000) begin
            s_next.state = fault_status_pkg::ST_ERROR;
        end else if (warn_in != 16'h0000) begin
            s_next.state = fault_status_pkg::ST_WARNING;
        end else begin
            s_next.state = fault_status_pkg::ST_NORMAL;
        end
        is_error   = s_next.state == fault_status_pkg::ST_ERROR;
        is_warning = s_next.state == fault_status_pkg::ST_WARNING;

        // Blink divider
        if (s_reg.blink_cnt >= BLINK_LAST) begin
            s_next.blink_cnt   = 24'h000000;
            s_next.blink_phase = ~s_reg.blink_phase;
        end else begin
            s_next.blink_cnt = s_reg.blink_cnt + 24'h000001;
        end

        // Lamp and display
        s_next.fault_lamp    = 1'b0;
        s_next.seg_digit     = 4'h0;
        s_next.seg_digit_en  = 1'b0;
        s_next.seg_status_en = 1'b1;
        if (is_error) begin
            s_next.fault_lamp    = 1'b1;
            s_next.seg_digit     = lowest_set(s_next.error_latch);
            s_next.seg_digit_en  = 1'b1;
            s_next.seg_status_en = 1'b0;
        end else if (s_next.startup_fault) begin
            s_next.fault_lamp = 1'b1;
        end else if (is_warning && s_next.blink_phase) begin
            s_next.fault_lamp    = 1'b1;
            s_next.seg_digit     = lowest_set(warn_in);
            s_next.seg_digit_en  = 1'b1;
            s_next.seg_status_en = 1'b0;
        end

        // Ready outputs
        s_next.ready_flag          = !is_error && !s_next.startup_fault;
        s_next.ready_relay_contact = s_next.ready_flag;
        s_next.ready_indicator     = s_next.ready_flag;

        // Interrupts
        irq_ev = 3'h0;
        irq_ev[`IRQ_ERROR]   = is_error && s_reg.state != fault_status_pkg::ST_ERROR;
        irq_ev[`IRQ_WARNING] = (warn_in & ~s_reg.warn) != 16'h0000;
        irq_ev[`IRQ_CLEARED] = s_reg.error_latch != 16'h0000
                               && s_next.error_latch == 16'h0000;
        s_next.irq_status = s_reg.irq_status;
        if (wr && addr == `OFS_IRQ_STATUS) begin
            s_next.irq_status = s_reg.irq_status & ~wdata[2:0];
        end
        s_next.irq_status = s_next.irq_status | irq_ev;
        if (wr && addr == `OFS_IRQ_MASK) begin
            s_next.irq_mask = wdata[2:0];
        end
        s_next.irq = (s_next.irq_status & s_next.irq_mask) != 3'h0;

        // Register reads
        s_next.rdata = 32'h00000000;
        if (rd) begin
            unique case (addr)
                `OFS_IGBT_TEMP:   s_next.rdata = {16'h0000, s_reg.igbt_temp};
                `OFS_DC_LINK:     s_next.rdata = {16'h0000, s_reg.dc_reading};
                `OFS_STATUS_WORD: begin
                    s_next.rdata[`BIT_WARN_BASE +: 16] = s_reg.warn;
                    s_next.rdata[`BIT_READY]   = s_reg.ready_flag;
                    s_next.rdata[`BIT_ERROR]   = s_reg.state == fault_status_pkg::ST_ERROR;
                    s_next.rdata[`BIT_STARTUP] = s_reg.startup_fault;
                end
                `OFS_IRQ_STATUS:  s_next.rdata = {29'h0, s_reg.irq_status};
                `OFS_IRQ_MASK:    s_next.rdata = {29'h0, s_reg.irq_mask};
                default:          s_next.rdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_reg                     <= '0;
            s_reg.state               <= fault_status_pkg::ST_NORMAL;
            s_reg.error_latch         <= `RST_WORD16;
            s_reg.irq_mask            <= `RST_IRQ_MASK;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata               = s_reg.rdata;
    assign fault_lamp          = s_reg.fault_lamp;
    assign seg_digit           = s_reg.seg_digit;
    assign seg_digit_en        = s_reg.seg_digit_en;
    assign seg_status_en       = s_reg.seg_status_en;
    assign ready_relay_contact = s_reg.ready_relay_contact;
    assign ready_indicator     = s_reg.ready_indicator;
    assign irq                 = s_reg.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    error_lamp_a: assert property (@(posedge clk) disable iff (!reset_n)
        |error_event |=> fault_lamp && seg_digit_en)
        else $error("error did not light lamp and digit");

    relay_open_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.state == fault_status_pkg::ST_ERROR) |-> !ready_relay_contact)
        else $error("relay closed during error");

    ready_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd && addr == `OFS_STATUS_WORD && s_reg.state == fault_status_pkg::ST_ERROR)
        |=> !rdata[`BIT_READY])
        else $error("ready flag read one during error");

    indicator_dark_a: assert property (@(posedge clk) disable iff (!reset_n)
        |error_event |=> !ready_indicator)
        else $error("ready indicator lit during error");

    latch_holds_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.error_latch != 16'h0000 && !clear_req) |=> s_reg.error_latch != 16'h0000)
        else $error("error latch lost without clear");

    clear_works_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clear_req && err_in == 16'h0000) |=> s_reg.error_latch == 16'h0000 ##1
        (s_reg.state != fault_status_pkg::ST_ERROR || $past(err_in) != 16'h0000))
        else $error("clear request did not clear errors");

    startup_blank_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.startup_fault && s_reg.state != fault_status_pkg::ST_ERROR)
        |-> fault_lamp && !seg_digit_en)
        else $error("power-up release shows a number");

    warn_blink_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.state == fault_status_pkg::ST_WARNING && !s_reg.startup_fault)
        |-> fault_lamp == seg_digit_en && seg_status_en == !seg_digit_en)
        else $error("warning lamp and display out of step");

    warn_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rd && addr == `OFS_STATUS_WORD) |=> rdata[31:16] == $past(s_reg.warn))
        else $error("warning bits misplaced in status word");

    motor_hot_a: assert property (@(posedge clk) disable iff (!reset_n)
        (motor_temp_pct > 9'h057) |=> s_reg.warn[6])
        else $error("motor temperature warning missing");

    dc_saturate_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_reg.dc_reading <= 16'h7FFF)
        else $error("link reading above saturation");

    overvolt_err_a: assert property (@(posedge clk) disable iff (!reset_n)
        (s_reg.dc_reading > 16'h778C) |=> s_reg.error_latch[8])
        else $error("overvoltage error not latched");

    unused_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_reg.warn[4:3] == 2'b00 && s_reg.warn[11:10] == 2'b00
        && s_reg.warn[14:13] == 2'b00)
        else $error("unassigned warning bit set");

endmodule : fault_warning_status_logic

// *** host_model.sv ***
// Model of the host side: drive release input and digital clear request.
// Assumes the testbench calls its tasks; signals change after a rising edge.
`timescale 1ns/1ps

module host_model (
    input  wire logic clk,
    output logic      clear_errors_input,
    output logic      drive_release_input
);
    initial begin
        clear_errors_input  = 1'b0;
        drive_release_input = 1'b0;
    end

    // ------------------------------------------------------------------
    // Release level
    // ------------------------------------------------------------------
    task automatic set_release(input logic v);
        @(posedge clk);
        drive_release_input <= v;
    endtask : set_release

    // ------------------------------------------------------------------
    // Clear request held for whole cycles
    // ------------------------------------------------------------------
    task automatic request_clear(input int unsigned n);
        @(posedge clk);
        clear_errors_input <= 1'b1;
        repeat (n) @(posedge clk);
        clear_errors_input <= 1'b0;
    endtask : request_clear
endmodule : host_model

// *** testbench.sv ***
// Self-checking bench of the fault and warning status block.
// Assumes host_model.sv, fault_status_defs.svh and a 20 MHz clock.
`timescale 1ns/1ps
`include "fault_status_defs.svh"

module testbench;
    localparam int unsigned BLINK = 4;
    logic        clk;
    logic        reset_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [31:0] rdata96;
    logic        lamp96;
    logic        irq96;
    logic [15:0] error_event;
    logic        clear_errors_input;
    logic        drive_release_input;
    logic        detect_inconsistent;
    logic        run_signal_warning;
    logic        fe_inactive;
    logic        supply_low;
    logic [8:0]  motor_temp_pct;
    logic [8:0]  unit_temp_pct;
    logic [8:0]  current_pct;
    logic [8:0]  thermal_overload_pct;
    logic [8:0]  ballast_pct;
    logic [15:0] link_voltage_q4;
    logic [15:0] igbt_temp_raw;
    logic        fault_lamp;
    logic [3:0]  seg_digit;
    logic        seg_digit_en;
    logic        seg_status_en;
    logic        ready_relay_contact;
    logic        ready_indicator;
    logic        irq;
    int          n_fail;
    int          check_count;
    logic [31:0] d;

    fault_warning_status_logic #(.BLINK_CYCLES(BLINK)) uut (.*);
    fault_warning_status_logic #(.BLINK_CYCLES(BLINK), .VARIANT_96V(1'b1)) uut96 (
        .*, .rdata(rdata96), .fault_lamp(lamp96), .seg_digit(), .seg_digit_en(),
        .seg_status_en(), .ready_relay_contact(), .ready_indicator(), .irq(irq96));
    host_model host (.clk(clk), .clear_errors_input(clear_errors_input),
        .drive_release_input(drive_release_input));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] pk(input logic l, input logic [3:0] g, input logic de,
            input logic se, input logic rr, input logic ri, input logic iq);
        return {22'h0, l, g & {4{de}}, de, se, rr, ri, iq};
    endfunction : pk

    function automatic logic [31:0] outs();
        return pk(fault_lamp, seg_digit, seg_digit_en, seg_status_en,
            ready_relay_contact, ready_indicator, irq);
    endfunction : outs

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    task automatic do_reset(input logic rel);
        host.set_release(rel);
        reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        wait_cyc(3);
    endtask : do_reset

    task automatic pulse_err(input int n);
        @(posedge clk);
        error_event <= 16'h0001 << n;
        @(posedge clk);
        error_event <= 16'h0000;
        wait_cyc(2);
    endtask : pulse_err

    task automatic set_warn(input logic [3:0] n, input logic on);
        @(posedge clk);
        case (n)
            4'h0: detect_inconsistent <= on;
            4'h1: run_signal_warning <= on;
            4'h2: fe_inactive <= on;
            4'h5: supply_low <= on;
            4'h6: motor_temp_pct <= on ? 9'h058 : 9'h057;
            4'h7: unit_temp_pct <= on ? 9'h058 : 9'h057;
            4'h8: link_voltage_q4 <= on ? 16'h04B0 : 16'h03E8;
            4'h9: current_pct <= on ? 9'h0C9 : 9'h0C8;
            4'hC: thermal_overload_pct <= on ? 9'h058 : 9'h057;
            default: ballast_pct <= on ? 9'h058 : 9'h057;
        endcase
        wait_cyc(3);
    endtask : set_warn

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_errors();
        check("idle outs", outs(), pk(1'b0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0));
        reg_rd(`OFS_STATUS_WORD);
        check("idle word", d, 32'h0000_0001);
        reg_wr(`OFS_IRQ_MASK, 32'h0000_0007);
        pulse_err(3);
        check("err outs", outs(), pk(1'b1, 4'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
        reg_rd(`OFS_STATUS_WORD);
        check("err word", d, 32'h0000_0002);
        host.set_release(1'b1);
        host.set_release(1'b0);
        pulse_err(9);
        check("held outs", outs(), pk(1'b1, 4'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
        host.request_clear(2);
        wait_cyc(3);
        check("clr outs", outs(), pk(1'b0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
        reg_wr(`OFS_IRQ_STATUS, 32'h0000_0007);
        wait_cyc(2);
        check("irq w1c", {31'h0, irq}, 32'h0);
        pulse_err(12);
        check("err c", outs(), pk(1'b1, 4'hC, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1));
        reg_wr(`OFS_CONTROL, 32'h0000_0001);
        wait_cyc(3);
        check("can clr", outs(), pk(1'b0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
        reg_wr(`OFS_IRQ_STATUS, 32'h0000_0007);
    endtask : test_errors

    task automatic test_warnings();
        logic [3:0] wl [10];
        wl = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hC, 4'hF};
        foreach (wl[i]) begin
            set_warn(wl[i], 1'b1);
            reg_rd(`OFS_STATUS_WORD);
            check("warn word", d, 32'h1 | (32'h1 << (16 + wl[i])));
            set_warn(wl[i], 1'b0);
            reg_rd(`OFS_STATUS_WORD);
            check("warn gone", d, 32'h0000_0001);
        end
    endtask : test_warnings

    task automatic test_blink();
        int on_cnt;
        on_cnt = 0;
        reg_wr(`OFS_IRQ_STATUS, 32'h0000_0007);
        wait_cyc(2);
        check("irq low", {31'h0, irq}, 32'h0);
        set_warn(4'h5, 1'b1);
        check("irq warn", {31'h0, irq}, 32'h1);
        repeat (16) begin
            wait_cyc(1);
            on_cnt += int'(fault_lamp === 1'b1);
            check("num shown", {31'h0, seg_digit_en}, {31'h0, fault_lamp});
            check("status shown", {31'h0, seg_status_en}, {31'h0, ~fault_lamp});
            if (fault_lamp === 1'b1) begin
                check("warn num", {28'h0, seg_digit}, 32'h0000_0005);
            end
        end
        check("blink duty", on_cnt, 32'h0000_0008);
        set_warn(4'h5, 1'b0);
        reg_wr(`OFS_IRQ_MASK, 32'h0000_0000);
        wait_cyc(2);
        check("irq masked", {31'h0, irq}, 32'h0);
    endtask : test_blink

    task automatic test_dc();
        logic [15:0] ql [3];
        logic [63:0] e48;
        logic [63:0] e96;
        ql = '{16'h0000, 16'h0300, 16'h0380};
        foreach (ql[i]) begin
            @(posedge clk);
            link_voltage_q4 <= ql[i];
            wait_cyc(3);
            e48 = (64'(ql[i]) * `SCALE_48V_Q8) >> `SCALE_SHIFT;
            e96 = (64'(ql[i]) * `SCALE_96V_Q8) >> `SCALE_SHIFT;
            reg_rd(`OFS_DC_LINK);
            check("dc 48", d, e48[31:0]);
            check("dc 96", rdata96, e96[31:0]);
        end
        @(posedge clk);
        link_voltage_q4 <= 16'h0600;
        wait_cyc(3);
        reg_rd(`OFS_DC_LINK);
        check("dc sat", d, {16'h0, `DC_SATURATE});
        check("err 8", outs(), pk(1'b1, 4'h8, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
        check("lamp 96", {31'h0, lamp96}, 32'h0);
        check("irq 96", {31'h0, irq96}, 32'h0);
        set_warn(4'h8, 1'b0);
        host.request_clear(2);
        wait_cyc(3);
        check("err 8 clr", outs(), pk(1'b0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0));
    endtask : test_dc

    task automatic test_regs();
        @(posedge clk);
        igbt_temp_raw <= 16'h64DB;
        wait_cyc(2);
        reg_rd(`OFS_IGBT_TEMP);
        check("igbt temp", d, 32'h0000_64DB);
        reg_wr(`OFS_STATUS_WORD, 32'hFFFF_FFFF);
        reg_rd(`OFS_STATUS_WORD);
        check("ro word", d, 32'h0000_0001);
        wait_cyc(1);
        check("rdata drop", rdata, 32'h0);
        reg_rd(8'h10);
        check("unmapped", d, 32'h0);
        reg_wr(`OFS_IRQ_MASK, 32'h0000_0005);
        reg_rd(`OFS_IRQ_MASK);
        check("mask rb", d, 32'h0000_0005);
    endtask : test_regs

    task automatic test_powerup();
        do_reset(1'b1);
        check("pwr outs", outs(), pk(1'b1, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
        reg_rd(`OFS_STATUS_WORD);
        check("pwr word", d & 32'h0000_0005, 32'h0000_0004);
        host.set_release(1'b0);
        host.request_clear(2);
        wait_cyc(3);
        check("pwr clr", outs(), pk(1'b0, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0));
    endtask : test_powerup

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    initial begin
        n_fail = 0;
        check_count = 0;
        reset_n = 1'b0;
        {addr, wdata, wr, rd, error_event, igbt_temp_raw} = '0;
        {detect_inconsistent, run_signal_warning, fe_inactive, supply_low} = 4'h0;
        {motor_temp_pct, unit_temp_pct, thermal_overload_pct, ballast_pct} = {4{9'h057}};
        current_pct = 9'h0C8;
        link_voltage_q4 = 16'h03E8;
        do_reset(1'b0);
        test_errors();
        test_warnings();
        test_blink();
        test_dc();
        test_regs();
        test_powerup();
        stop_test();
    end
endmodule : testbench
